// file: shared/dsw_pkg.sv
// package: constants and carriers for the deep standby wake and retention block
package dsw_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFS_WAKE_LEVEL  = 8'h00;
    localparam logic [7:0] OFS_RETENTION   = 8'h04;
    localparam logic [7:0] OFS_RET_ENABLE  = 8'h08;
    localparam logic [7:0] OFS_STATUS      = 8'h0c;
    localparam logic [7:0] OFS_BACKUP_0    = 8'h10;
    localparam logic [7:0] OFS_BACKUP_1    = 8'h14;
    localparam logic [7:0] OFS_BACKUP_2    = 8'h18;
    localparam logic [7:0] OFS_BACKUP_3    = 8'h1c;

    // backup store layout: four words of four bytes
    localparam int unsigned BACKUP_WORDS   = 4;
    localparam int unsigned BACKUP_BYTES   = 16;
    localparam int unsigned BYTE_W         = 8;

    // wake pins: pin zero plus five selectable pins
    localparam int unsigned WAKE_PINS      = 6;
    localparam int unsigned SEL_PINS       = 5;

    // field layouts
    localparam int unsigned LEVEL_LSB      = 0;
    localparam int unsigned ENABLE_LSB     = 3;
    localparam int unsigned KEEP_W         = 2;
    localparam int unsigned VDC_W          = 4;
    localparam int unsigned STAT_PIN_LSB   = 0;
    localparam int unsigned STAT_REQ_BIT   = 8;
    localparam int unsigned STAT_STBY_BIT  = 9;

    // reset values
    localparam logic [4:0]  LEVEL_RST      = 5'h00;
    localparam logic [4:0]  ENABLE_RST     = 5'h00;
    localparam logic [1:0]  KEEP_RST       = 2'h0;
    localparam logic [7:0]  BACKUP_RST     = 8'h00;
    localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

    // retention field encodings
    localparam logic [1:0]  KEEP_NONE      = 2'h0;
    localparam logic [1:0]  KEEP_BANK1     = 2'h1;
    localparam logic [1:0]  KEEP_BANK0     = 2'h2;
    localparam logic [1:0]  KEEP_ALL       = 2'h3;

    // voltage-detect configuration that arms the backup clear
    localparam logic [3:0]  VDC_CLEAR_CODE = 4'h1;

    // software side of the register port
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    // reset causes seen by the always-on domain
    typedef struct packed {
        logic lvd;
        logic standby_entry;
        logic other;
    } reset_cause_s;

    // per-bank keep decision toward the sram power switches
    typedef struct packed {
        logic bank1;
        logic bank0;
    } sram_keep_s;

endpackage

// file: src/deep_standby_wake_retention.sv
// always-on wake level detection, sram retention control and backup bytes
//
// How it works
// - pins one to five each have a level bit; 0 wakes on low, 1 on high.
// - pin zero has no level bit and always wakes on low input.
// - detection is level based, so an active pin at entry wakes at once.
// - the wake level register survives the deep standby transition reset.
// - reserved bits of level and retention registers read zero, ignore writes.
// - keep field resets to 00; 11 keeps all; 01 and 10 barred on standard parts.
// - on two-bank parts 01 keeps bank one, 10 keeps bank zero, 11 both.
// - retention register clears only on power-on and low-voltage resets.
// - retention register exists only on parts that can retain sram.
// - sixteen read-write backup bytes, four per word, reset to zero.
// - backup clears on power-on and low-voltage reset, optionally gated by config.
// - a wake pin shared with an enabled analog input is blocked.
// - pins one to five need their return enable; pin zero always enabled.

module deep_standby_wake_retention
    import dsw_pkg::*;
#(
    parameter bit TWO_BANK_VARIANT = 1'b0,
    parameter bit HAS_RETENTION    = 1'b1,
    parameter bit LVD_CFG_GATED    = 1'b0
) (
    // clock and power-on reset
    input  wire logic                        clk_sys_in,
    input  wire logic                        sys_rst_in,

    // other reset causes, same clock domain
    input  wire dsw_pkg::reset_cause_s       reset_cause_in,
    input  wire logic [dsw_pkg::VDC_W-1:0]   voltage_detect_config_in,

    // register port
    input  wire dsw_pkg::reg_req_s           reg_req_in,
    output logic [dsw_pkg::DATA_W-1:0]       reg_rdata_out,

    // power controller
    input  wire logic                        in_standby_in,
    output logic                             wake_request_out,
    output dsw_pkg::sram_keep_s              sram_keep_out,

    // wake pins and their analog enables
    input  wire logic [dsw_pkg::WAKE_PINS-1:0] wake_pin_in,
    input  wire logic [dsw_pkg::WAKE_PINS-1:0] analog_input_enable_in
);
    import dsw_pkg::*;

    // helpers
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [DATA_W-1:0] pack_word(input logic [1:0] w,
                                                    input logic [7:0] m [BACKUP_BYTES]);
        logic [DATA_W-1:0] v;
        v = READ_ZERO;
        for (int b = 0; b < 4; b++) begin
            v[b*BYTE_W +: BYTE_W] = m[{w, 2'(b)}];
        end
        pack_word = v;
    endfunction

    // state
    logic [SEL_PINS-1:0]  level_sel_reg;
    logic [SEL_PINS-1:0]  ret_enable_reg;
    logic [KEEP_W-1:0]    sram_keep_field_reg;
    logic [7:0]           backup_bytes [BACKUP_BYTES];
    logic [WAKE_PINS-1:0] pin_meta_reg;
    logic [WAKE_PINS-1:0] pin_sync_reg;
    logic                 wake_req_reg;
    logic [DATA_W-1:0]    rdata_reg;
    logic [DATA_W-1:0]    rdata_next;

    // retained registers clear on power-on or low-voltage reset only;
    // the standby entry reset and other causes do not reach them
    wire clear_retained = sys_rst_in | reset_cause_in.lvd;

    // backup clear, optionally armed by the voltage-detect configuration
    wire lvd_backup_ok  = !LVD_CFG_GATED || (voltage_detect_config_in == VDC_CLEAR_CODE);
    wire clear_backup   = sys_rst_in | (reset_cause_in.lvd & lvd_backup_ok);

    // bus decode
    wire wr = reg_req_in.wr;
    wire rd = reg_req_in.rd;
    wire [ADDR_W-1:0] addr = reg_req_in.addr;
    wire [DATA_W-1:0] wdata = reg_req_in.wdata;

    wire sel_level   = hit(addr, OFS_WAKE_LEVEL);
    wire sel_keep    = hit(addr, OFS_RETENTION) & HAS_RETENTION;
    wire sel_enable  = hit(addr, OFS_RET_ENABLE);
    wire sel_status  = hit(addr, OFS_STATUS);
    wire sel_backup  = (addr >= OFS_BACKUP_0) && (addr <= OFS_BACKUP_3)
                       && (addr[1:0] == 2'h0);
    wire [1:0] bk_word = 2'(addr[3:2]);

    // keep field write filter: standard parts refuse the split encodings
    wire [KEEP_W-1:0] keep_wval = wdata[KEEP_W-1:0];
    wire keep_split  = (keep_wval == KEEP_BANK1) || (keep_wval == KEEP_BANK0);
    wire keep_wr_ok  = wr & sel_keep & (TWO_BANK_VARIANT | !keep_split);

    // pin synchroniser, second stage is the only reader of the first
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pin_meta_reg <= '1;
            pin_sync_reg <= '1;
        end else begin
            pin_meta_reg <= wake_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // level and enable registers, five bits each: level at bits 4:0, enable at bits 7:3
    always_ff @(posedge clk_sys_in) begin
        if (clear_retained) begin
            level_sel_reg  <= LEVEL_RST;
            ret_enable_reg <= ENABLE_RST;
        end else begin
            if (wr && sel_level) begin
                level_sel_reg <= wdata[LEVEL_LSB +: SEL_PINS];
            end
            if (wr && sel_enable) begin
                ret_enable_reg <= wdata[ENABLE_LSB +: SEL_PINS];
            end
        end
    end

    // retention field
    always_ff @(posedge clk_sys_in) begin
        if (clear_retained) begin
            sram_keep_field_reg <= KEEP_RST;
        end else if (keep_wr_ok) begin
            sram_keep_field_reg <= keep_wval;
        end
    end

    // backup bytes, whole-word writes
    always_ff @(posedge clk_sys_in) begin
        if (clear_backup) begin
            for (int i = 0; i < BACKUP_BYTES; i++) begin
                backup_bytes[i] <= BACKUP_RST;
            end
        end else if (wr && sel_backup) begin
            for (int b = 0; b < 4; b++) begin
                backup_bytes[{bk_word, 2'(b)}] <= wdata[b*BYTE_W +: BYTE_W];
            end
        end
    end

    // wake comparison
    // pin zero wakes on low and is always enabled; the others follow their
    // level and enable bits; an analog-enabled pin is masked regardless
    wire [WAKE_PINS-1:0] active_level = {level_sel_reg, 1'b0};
    wire [WAKE_PINS-1:0] pin_enabled  = {ret_enable_reg, 1'b1};
    wire [WAKE_PINS-1:0] pin_match    = ~(pin_sync_reg ^ active_level)
                                        & pin_enabled
                                        & ~analog_input_enable_in;
    wire wake_any = |pin_match;

    // no edge memory: a pin already at its level on entry wakes at once
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in || reset_cause_in.standby_entry) begin
            wake_req_reg <= 1'b0;
        end else begin
            wake_req_reg <= in_standby_in & wake_any;
        end
    end

    // keep decision toward the bank switches
    wire keep_b0 = HAS_RETENTION && ((sram_keep_field_reg == KEEP_ALL)
                   || (TWO_BANK_VARIANT && sram_keep_field_reg == KEEP_BANK0));
    wire keep_b1 = HAS_RETENTION && ((sram_keep_field_reg == KEEP_ALL)
                   || (TWO_BANK_VARIANT && sram_keep_field_reg == KEEP_BANK1));

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_next = READ_ZERO;
        if (sel_level) begin
            rdata_next[LEVEL_LSB +: SEL_PINS] = level_sel_reg;
        end else if (sel_keep) begin
            rdata_next[KEEP_W-1:0] = sram_keep_field_reg;
        end else if (sel_enable) begin
            rdata_next[ENABLE_LSB +: SEL_PINS] = ret_enable_reg;
        end else if (sel_status) begin
            rdata_next[STAT_PIN_LSB +: WAKE_PINS] = pin_match;
            rdata_next[STAT_REQ_BIT]  = wake_req_reg;
            rdata_next[STAT_STBY_BIT] = in_standby_in;
        end else if (sel_backup) begin
            rdata_next = pack_word(bk_word, backup_bytes);
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rdata_reg <= READ_ZERO;
        end else begin
            rdata_reg <= rd ? rdata_next : READ_ZERO;
        end
    end

    assign reg_rdata_out      = rdata_reg;
    assign wake_request_out   = wake_req_reg;
    assign sram_keep_out.bank0 = keep_b0;
    assign sram_keep_out.bank1 = keep_b1;

endmodule

// file: testbench/dsw_asserts.sv
// port assertions for the deep standby wake and retention block
module dsw_asserts
    import dsw_pkg::*;
#(
    parameter bit TWO_BANK = 1'b0
) (
    // clock and reset
    input wire logic                     clk_sys_in,
    input wire logic                     sys_rst_in,
    // watched ports
    input wire dsw_pkg::reset_cause_s    reset_cause_in,
    input wire dsw_pkg::reg_req_s        reg_req_in,
    input wire logic [dsw_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic                     in_standby_in,
    input wire logic                     wake_request_out,
    input wire dsw_pkg::sram_keep_s      sram_keep_out,
    input wire logic [dsw_pkg::WAKE_PINS-1:0] wake_pin_in,
    input wire logic [dsw_pkg::WAKE_PINS-1:0] analog_input_enable_in
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    // pin zero low and unmasked long enough to pass the synchroniser
    sequence s_pin0_low;
        (!wake_pin_in[0] && !analog_input_enable_in[0] && in_standby_in
         && !reset_cause_in.standby_entry)[*3];
    endsequence
    sequence s_all_masked;
        (&analog_input_enable_in)[*3];
    endsequence

    chk_keep_reset: assert property (@(posedge clk_sys_in) disable iff (1'b0)
        $fell(sys_rst_in) |-> sram_keep_out == 2'h0) else $error("keep not cleared");
    // split keep codes are legal only on the two-bank part
    chk_keep_pair: assert property (TWO_BANK || (sram_keep_out.bank0 == sram_keep_out.bank1))
        else $error("standard part kept one bank");
    chk_lvd_keep: assert property (reset_cause_in.lvd && !reg_req_in.wr |=>
        sram_keep_out == 2'h0) else $error("lvd left keep set");
    chk_keep_hold: assert property ((reset_cause_in.standby_entry || reset_cause_in.other)
        && !reset_cause_in.lvd && !reg_req_in.wr |=> $stable(sram_keep_out))
        else $error("keep lost on other reset");
    chk_wake_zero: assert property (s_pin0_low |=> wake_request_out)
        else $error("pin zero low gave no wake");
    chk_wake_block: assert property (s_all_masked |=> !wake_request_out)
        else $error("masked pins woke");
    chk_wake_drop: assert property (!in_standby_in |=> !wake_request_out)
        else $error("wake outside standby");
    chk_rdata_idle: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == '0)
        else $error("read data outside read slot");
endmodule

// file: testbench/wake_pin_model.sv
// external wake pins: levels follow the request after a slow pin delay
module wake_pin_model #(
    parameter int DELAY = 2
) (
    input  wire logic       clk_in,
    input  wire logic [5:0] target_in,
    output logic      [5:0] pins_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] pipe_reg [DELAY];
    // pins settle a few cycles late, as slow board edges do
    always_ff @(posedge clk_in) begin
        pipe_reg[0] <= target_in;
        for (int i = 1; i < DELAY; i++) pipe_reg[i] <= pipe_reg[i-1];
    end
    assign pins_out = pipe_reg[DELAY-1];
endmodule

// file: testbench/deep_standby_wake_retention_bench.sv
// self-checking bench for the deep standby wake and retention block
module deep_standby_wake_retention_bench
    import dsw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk_sys_in = 1'b0;
    logic         sys_rst_in = 1'b1;
    reset_cause_s cause      = '0;
    reg_req_s     req        = '0;
    logic [31:0]  rdata;
    logic         stby       = 1'b0;
    logic         wake;
    sram_keep_s   keep;
    logic [31:0]  rdata_two;
    logic         wake_two;
    sram_keep_s   keep_two;
    logic [5:0]   target     = 6'h3f;
    logic [5:0]   pins;
    logic [5:0]   ana        = 6'h00;
    int           failures   = 0;
    int           checked    = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    wake_pin_model u_pins (.clk_in(clk_sys_in), .target_in(target), .pins_out(pins));
    deep_standby_wake_retention u_dut (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reset_cause_in(cause),
        .voltage_detect_config_in(4'h0), .reg_req_in(req), .reg_rdata_out(rdata),
        .in_standby_in(stby), .wake_request_out(wake), .sram_keep_out(keep),
        .wake_pin_in(pins), .analog_input_enable_in(ana));
    // two-bank part on the same bus, so split keep codes are exercised
    deep_standby_wake_retention #(.TWO_BANK_VARIANT(1'b1)) u_dut_two (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reset_cause_in(cause),
        .voltage_detect_config_in(4'h0), .reg_req_in(req), .reg_rdata_out(rdata_two),
        .in_standby_in(stby), .wake_request_out(wake_two), .sram_keep_out(keep_two),
        .wake_pin_in(pins), .analog_input_enable_in(ana));

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        req.rd <= 1'b0;
        #1 check($sformatf("rdata at %h", a), e, rdata);
    endtask
    task automatic pulse(input reset_cause_s c);
        @(posedge clk_sys_in);
        cause <= c;
        @(posedge clk_sys_in);
        cause <= '0;
    endtask
    task automatic rd_kept(input logic on);
        rd(OFS_WAKE_LEVEL, on ? 32'h1f : 32'h0);
        rd(OFS_RETENTION, on ? 32'h3 : 32'h0);
        for (int k = 0; k < 4; k++) begin
            rd(8'(OFS_BACKUP_0 + 4 * k), on ? 32'ha5c3_0f10 + k : 32'h0);
        end
    endtask
    // pins and masks are set outside standby so entry sees them already active
    task automatic wake_case(input logic [5:0] p, input logic [5:0] an, input logic e);
        @(posedge clk_sys_in);
        target <= p;
        ana    <= an;
        stby   <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        stby <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        #1 check("wake_request_out", {31'h0, e}, {31'h0, wake});
    endtask

    task automatic t_reset();
        for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
        rd(8'h40, 32'h0);
        $display("test reset values done");
    endtask
    task automatic t_regs();
        wr(OFS_WAKE_LEVEL, 32'hffff_ffff);
        rd(OFS_WAKE_LEVEL, 32'h1f);
        wr(OFS_RETENTION, 32'hffff_ffff);
        rd(OFS_RETENTION, 32'h3);
        wr(OFS_RETENTION, 32'h1);
        wr(OFS_RETENTION, 32'h2);
        rd(OFS_RETENTION, 32'h3);
        check("sram_keep_out", 32'h3, {30'h0, keep});
        for (int k = 0; k < 4; k++) wr(8'(OFS_BACKUP_0 + 4 * k), 32'ha5c3_0f10 + k);
        rd_kept(1'b1);
        pulse('{lvd: 1'b0, standby_entry: 1'b1, other: 1'b0});
        rd_kept(1'b1);
        pulse('{lvd: 1'b0, standby_entry: 1'b0, other: 1'b1});
        rd_kept(1'b1);
        pulse('{lvd: 1'b1, standby_entry: 1'b0, other: 1'b0});
        rd_kept(1'b0);
        $display("test registers done");
    endtask
    task automatic t_two_bank();
        wr(OFS_RETENTION, 32'h1);
        #1 check("sram_keep_out", 32'h0, {30'h0, keep});
        check("two-bank sram_keep_out", 32'h2, {30'h0, keep_two});
        wr(OFS_RETENTION, 32'h2);
        #1 check("two-bank sram_keep_out", 32'h1, {30'h0, keep_two});
        rd(OFS_RETENTION, 32'h0);
        check("two-bank rdata", 32'h2, rdata_two);
        wr(OFS_RETENTION, 32'h3);
        #1 check("two-bank sram_keep_out", 32'h3, {30'h0, keep_two});
        $display("test two-bank keep done");
    endtask
    task automatic t_wake();
        logic [5:0] b;
        wr(OFS_RET_ENABLE, 32'hf8);
        for (int n = 1; n < 6; n++) begin
            b = 6'(1 << n);
            wr(OFS_WAKE_LEVEL, 32'h0);
            wake_case(~b, 6'h00, 1'b1);
            wake_case(~b, b, 1'b0);
            wr(OFS_WAKE_LEVEL, 32'(1 << (n - 1)));
            wake_case(6'h3f, 6'h00, 1'b1);
            wake_case(~b, 6'h00, 1'b0);
        end
        wr(OFS_RET_ENABLE, 32'h0);
        wake_case(6'h3f, 6'h00, 1'b0);
        wake_case(6'h3e, 6'h3f, 1'b0);
        wake_case(6'h3e, 6'h00, 1'b1);
        $display("test wake pins done");
    endtask

    initial begin
        repeat (16) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_regs();
        t_two_bank();
        t_wake();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        failures++;
        end_of_test();
    end
endmodule

bind deep_standby_wake_retention dsw_asserts #(.TWO_BANK(TWO_BANK_VARIANT)) u_chk (
    .clk_sys_in, .sys_rst_in, .reset_cause_in, .reg_req_in, .reg_rdata_out,
    .in_standby_in, .wake_request_out, .sram_keep_out, .wake_pin_in,
    .analog_input_enable_in);
